//--- design/tci_regs.vh
`ifndef TCI_REGS_VH
`define TCI_REGS_VH
`define TCI_ADDR_LOW 7'h4a
`define TCI_ADDR_HIGH 7'h4b
`define TCI_RW_BIT 0
`define TCI_CKSUM_BIT 7
`define TCI_CRC_POLY 8'h07
`define TCI_CRC_INIT 8'h00
`define TCI_PTR_RST 16'h0000
`endif

//--- design/tci_i2c_slave.v
// Summary of operation
// - strap high selects usb, low i2c
// - second strap picks plain or hid protocol
// - address 0x4a if select low, else 0x4b
// - address in bits 7..1, bit0 direction
// - two pointer bytes, low first, stored
// - data bytes go to consecutive addresses
// - stop restores pointer to write start
// - change line low while data pending
// - raw debug stream goes to usb
// - drive supply enabled after pin test passes
// - pointer top bit selects crc checked write
// - read auto-increments, nack restores pointer
`include "tci_regs.vh"
module tci_i2c_slave #(
  parameter AW = 16
) (
  input wire clk,
  input wire arst_n,
  input wire host_iface_select_strap,
  input wire hid_protocol_select_strap,
  input wire slave_addr_select,
  input wire scl_i,
  input wire sda_i,
  output wire sda_o,
  output wire sda_oe_n,
  output wire usb_sel,
  output wire i2c_plain_sel,
  output wire i2c_hid_sel,
  input wire usb_traffic,
  output wire debug_to_usb,
  input wire pin_test_done,
  input wire pin_test_pass,
  output reg drive_line_supply,
  input wire msg_pending,
  output wire change_pending_n,
  output reg [AW-1:0] wr_addr,
  output reg [7:0] wr_data,
  output reg wr_stb,
  output reg [AW-1:0] rd_addr,
  input wire [7:0] rd_data,
  output reg rd_stb,
  output reg cksum_mode,
  output reg crc_err
);
  localparam S_IDLE = 3'd0;
  localparam S_ADDR = 3'd1;
  localparam S_PLO = 3'd2;
  localparam S_PHI = 3'd3;
  localparam S_WDAT = 3'd4;
  localparam S_RDAT = 3'd5;
  localparam S_SKIP = 3'd6;

  function [7:0] crc8;
    input [7:0] c;
    input [7:0] d;
    integer i;
    reg [7:0] x;
    begin
      x = c ^ d;
      for (i = 0; i < 8; i = i + 1)
        x = x[7] ? ((x << 1) ^ `TCI_CRC_POLY) : (x << 1);
      crc8 = x;
    end
  endfunction

  reg rst_s1_q, rst_q;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_q <= 1'b0;
      rst_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_q <= rst_s1_q;
    end
  end
  wire rst_n = rst_q;

  assign usb_sel = host_iface_select_strap;
  assign i2c_plain_sel = !host_iface_select_strap &&
                         !hid_protocol_select_strap;
  assign i2c_hid_sel = !host_iface_select_strap &&
                       hid_protocol_select_strap;
  assign debug_to_usb = usb_traffic;
  assign change_pending_n = !msg_pending;

  // address strap caught once after reset release
  reg strap_done_q;
  reg [6:0] own_addr_q;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_done_q <= 1'b0;
      own_addr_q <= `TCI_ADDR_HIGH;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      own_addr_q <= slave_addr_select ? `TCI_ADDR_HIGH
                                      : `TCI_ADDR_LOW;
    end
  end

  // supply stays off until pin test reports a pass
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) drive_line_supply <= 1'b0;
    else if (pin_test_done && pin_test_pass)
      drive_line_supply <= 1'b1;
  end

  reg scl_q, sda_q;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
    end
  end
  wire start_c = scl_i && scl_q && sda_q && !sda_i;
  wire stop_c = scl_i && scl_q && !sda_q && sda_i;
  wire scl_rise = scl_i && !scl_q;
  wire scl_fall = !scl_i && scl_q;

  reg [2:0] st_q;
  reg [7:0] sh_q;
  reg [3:0] bit_q;
  reg ack_q, drv_q, rd_nack_q;
  reg [AW-1:0] start_ptr_q, ptr_q;
  reg [7:0] crc_q;
  reg got_data_q;
  assign sda_o = 1'b0;
  assign sda_oe_n = !drv_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= S_IDLE;
      sh_q <= 8'h00;
      bit_q <= 4'h0;
      ack_q <= 1'b0;
      drv_q <= 1'b0;
      rd_nack_q <= 1'b0;
      start_ptr_q <= `TCI_PTR_RST;
      ptr_q <= `TCI_PTR_RST;
      crc_q <= `TCI_CRC_INIT;
      got_data_q <= 1'b0;
      wr_addr <= {AW{1'b0}};
      wr_data <= 8'h00;
      wr_stb <= 1'b0;
      rd_addr <= {AW{1'b0}};
      rd_stb <= 1'b0;
      cksum_mode <= 1'b0;
      crc_err <= 1'b0;
    end else begin
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
      if (start_c) begin
        st_q <= S_ADDR;
        bit_q <= 4'h0;
        ack_q <= 1'b0;
        drv_q <= 1'b0;
        crc_q <= `TCI_CRC_INIT;
      end else if (stop_c) begin
        if (cksum_mode && got_data_q && st_q == S_WDAT)
          crc_err <= (crc_q != `TCI_CRC_INIT);
        if (st_q == S_WDAT || st_q == S_PHI || st_q == S_PLO)
          ptr_q <= start_ptr_q;
        st_q <= S_IDLE;
        drv_q <= 1'b0;
        got_data_q <= 1'b0;
      end else if (st_q != S_IDLE && st_q != S_SKIP) begin
        if (scl_rise && !ack_q) begin
          // read bits stay put; the index walks them instead
          if (st_q != S_RDAT)
            sh_q <= {sh_q[6:0], sda_i};
          else if (bit_q == 4'd8)
            rd_nack_q <= sda_i;
          bit_q <= bit_q + 4'd1;
        end
        if (scl_fall) begin
          if (ack_q) begin
            ack_q <= 1'b0;
            drv_q <= (st_q == S_RDAT) && !rd_data[7];
            sh_q <= rd_data;
            bit_q <= 4'h0;
          end else if (st_q == S_RDAT) begin
            if (bit_q == 4'd9) begin
              bit_q <= 4'h0;
              if (rd_nack_q) begin
                ptr_q <= start_ptr_q;
                st_q <= S_SKIP;
                drv_q <= 1'b0;
              end else begin
                sh_q <= rd_data;
                drv_q <= !rd_data[7];
              end
            end else if (bit_q == 4'd8) begin
              // next byte fetched while the host acks this one
              drv_q <= 1'b0;
              ptr_q <= ptr_q + 1'b1;
              rd_addr <= ptr_q + 1'b1;
              rd_stb <= 1'b1;
            end else begin
              drv_q <= !sh_q[7 - bit_q[2:0]];
            end
          end else if (bit_q == 4'd8) begin
            ack_q <= 1'b1;
            drv_q <= 1'b1;
            crc_q <= crc8(crc_q, sh_q);
            case (st_q)
              S_ADDR: begin
                if (sh_q[7:1] != own_addr_q) begin
                  st_q <= S_SKIP;
                  ack_q <= 1'b0;
                  drv_q <= 1'b0;
                end else if (sh_q[`TCI_RW_BIT]) begin
                  st_q <= S_RDAT;
                  start_ptr_q <= ptr_q;
                  rd_addr <= ptr_q;
                  rd_stb <= 1'b1;
                end else begin
                  st_q <= S_PLO;
                end
              end
              S_PLO: begin
                ptr_q[7:0] <= sh_q;
                st_q <= S_PHI;
              end
              S_PHI: begin
                // top bit flags crc mode, not part of the address
                ptr_q <= {1'b0, sh_q[6:0], ptr_q[7:0]};
                start_ptr_q <= {1'b0, sh_q[6:0], ptr_q[7:0]};
                cksum_mode <= sh_q[`TCI_CKSUM_BIT];
                st_q <= S_WDAT;
              end
              S_WDAT: begin
                // byte written even if a later crc fails
                wr_addr <= ptr_q;
                wr_data <= sh_q;
                wr_stb <= 1'b1;
                ptr_q <= ptr_q + 1'b1;
                got_data_q <= 1'b1;
              end
              default: st_q <= S_SKIP;
            endcase
          end
        end
      end
    end
  end
endmodule // tci_i2c_slave

//--- verif/tci_i2c_slave_checker.sv
module tci_i2c_checker (
  input wire clk,
  input wire arst_n,
  input wire host_iface_select_strap,
  input wire hid_protocol_select_strap,
  input wire usb_sel,
  input wire i2c_plain_sel,
  input wire i2c_hid_sel,
  input wire pin_test_done,
  input wire pin_test_pass,
  input wire drive_line_supply,
  input wire msg_pending,
  input wire change_pending_n,
  input wire wr_stb
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire i2c = !host_iface_select_strap;
  wire hid = hid_protocol_select_strap;
  wire ok = pin_test_done && pin_test_pass;
  a_usb_select: assert property (usb_sel == !i2c)
    else $error("usb select wrong");
  a_hid_select: assert property (i2c_hid_sel == (i2c && hid))
    else $error("hid select wrong");
  a_plain_select: assert property (i2c_plain_sel == (i2c && !hid))
    else $error("plain select wrong");
  a_change_line: assert property (change_pending_n == !msg_pending)
    else $error("change line wrong");
  a_supply_held: assert property ((!ok)[*3] |=> !$rose(drive_line_supply))
    else $error("supply on before test pass");
  // six cycles leave room for the reset synchroniser
  a_supply_on: assert property (ok[*6] |-> drive_line_supply)
    else $error("supply not enabled");
  a_supply_kept: assert property (drive_line_supply |=> drive_line_supply)
    else $error("supply dropped");
  a_wr_pulse: assert property (wr_stb |=> !wr_stb)
    else $error("write strobe too long");
  cover property (wr_stb);
  cover property ($rose(drive_line_supply));
  cover property (!change_pending_n);
endmodule // tci_i2c_checker

bind tci_i2c_slave tci_i2c_checker u_chk (.*);

//--- verif/tci_host.sv
module tci_host (
  input wire clk,
  input wire sda,
  output logic scl,
  output logic sda_h
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl = 1'b1;
    sda_h = 1'b1;
  end
  task automatic q();
    repeat (4) @(posedge clk);
  endtask
  task automatic start();
    sda_h <= 1'b0;
    q();
    scl <= 1'b0;
    q();
  endtask
  task automatic stop();
    sda_h <= 1'b0;
    q();
    scl <= 1'b1;
    q();
    sda_h <= 1'b1;
    q();
  endtask
  // ninth bit released: slave acks a write, host nacks a read
  task automatic put(input logic [7:0] b, output logic ack,
                     output logic [7:0] r);
    logic [8:0] v;
    v = {b, 1'b1};
    r = 8'h00;
    ack = 1'b0;
    for (int i = 8; i >= 0; i--) begin
      sda_h <= v[i];
      q();
      scl <= 1'b1;
      q();
      if (i > 0)
        r[i - 1] = sda;
      else
        ack = !sda;
      scl <= 1'b0;
      q();
    end
  endtask
endmodule // tci_host

//--- verif/tb_touch_ctrl_i2c_slave_write.sv
module tb_touch_ctrl_i2c_slave_write;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, arst_n = 1'b0, scl, sda_h, a;
  logic host_iface_select_strap = 1'b0, hid_protocol_select_strap = 1'b0;
  logic slave_addr_select = 1'b0, usb_traffic = 1'b0, msg_pending = 1'b0;
  logic pin_test_done = 1'b0, pin_test_pass = 1'b0;
  logic [7:0] rd_data = 8'h3c;
  logic [7:0] rb;
  wire sda_o, sda_oe_n, usb_sel, i2c_plain_sel, i2c_hid_sel, debug_to_usb;
  wire drive_line_supply, change_pending_n, wr_stb, rd_stb, cksum_mode;
  wire crc_err;
  wire [15:0] wr_addr, rd_addr;
  wire [7:0] wr_data;
  wire sda_i = sda_h & (sda_oe_n | sda_o);
  int n_mismatch = 0, cmp_count = 0, cyc = 0;
  logic [23:0] wq[$];
  logic [15:0] rq[$];
  tci_i2c_slave dut (.*, .scl_i(scl));
  // bus side brings no reference clock in i2c mode
  tci_host u_host (.clk(clk), .sda(sda_i), .scl(scl), .sda_h(sda_h));
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (wr_stb === 1'b1) wq.push_back({wr_addr, wr_data});
    if (rd_stb === 1'b1) rq.push_back(rd_addr);
    if (cyc == 10000) begin
      n_mismatch++;
      conclude();
    end
  end
  task automatic chk(input string nm, input logic [23:0] s, e);
    cmp_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic sb(input logic [7:0] b, input logic e);
    u_host.put(b, a, rb);
    chk("ack", 24'(a), 24'(e));
  endtask
  // crc byte is also stored as data, even when it is wrong
  task automatic crc_wr(input logic [7:0] c, input logic e);
    u_host.start();
    sb(8'h94, 1'b1);
    sb(8'h34, 1'b1);
    sb(8'h92, 1'b1);
    chk("crc", 24'(cksum_mode), 24'h1);
    sb(8'h96, 1'b1);
    sb(c, 1'b1);
    u_host.stop();
    chk("wr2", wq.pop_front(), 24'h123496);
    chk("wr3", wq.pop_front(), {16'h1235, c});
    chk("crcerr", 24'(crc_err), 24'(e));
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      {host_iface_select_strap, hid_protocol_select_strap} <= 2'(i);
      {usb_traffic, msg_pending} <= 2'(i);
      #1 chk("usb", 24'(usb_sel), 24'(i[1]));
      chk("hid", 24'(i2c_hid_sel), 24'(i == 1));
      chk("plain", 24'(i2c_plain_sel), 24'(i == 0));
      chk("dbg", 24'(debug_to_usb), 24'(i[1]));
      chk("change", 24'(change_pending_n), 24'(!i[0]));
    end
    @(posedge clk);
    {host_iface_select_strap, hid_protocol_select_strap} <= 2'b00;
    pin_test_done <= 1'b1;
    repeat (4) @(posedge clk);
    #1 chk("hv", 24'(drive_line_supply), 24'h0);
    @(posedge clk);
    pin_test_pass <= 1'b1;
    repeat (8) @(posedge clk);
    #1 chk("hv", 24'(drive_line_supply), 24'h1);
    @(posedge clk);
    pin_test_pass <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk("hv", 24'(drive_line_supply), 24'h1);
    $display("test straps and supply done");
    u_host.start();
    sb(8'h96, 1'b0);
    u_host.stop();
    u_host.start();
    sb(8'h94, 1'b1);
    sb(8'h34, 1'b1);
    sb(8'h12, 1'b1);
    chk("mode", 24'(cksum_mode), 24'h0);
    sb(8'ha5, 1'b1);
    sb(8'h5a, 1'b1);
    u_host.stop();
    chk("wr0", wq.pop_front(), 24'h1234a5);
    chk("wr1", wq.pop_front(), 24'h12355a);
    $display("test write done");
    // no pointer bytes here, so the read shows where stop left it;
    // the second read shows that the nack put it back again
    for (int k = 0; k < 2; k++) begin
      u_host.start();
      sb(8'h95, 1'b1);
      u_host.put(8'hff, a, rb);
      u_host.stop();
      chk("rdat", 24'(rb), 24'h3c);
      chk("rd", 24'(rq[0]), 24'h1234);
      rq.delete();
    end
    $display("test read done");
    crc_wr(8'h5e, 1'b1);
    crc_wr(8'h64, 1'b0);
    $display("test checksum done");
    // second reset: address strap taken again, now high
    @(posedge clk);
    arst_n <= 1'b0;
    slave_addr_select <= 1'b1;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    #1 chk("hv", 24'(drive_line_supply), 24'h0);
    u_host.start();
    sb(8'h96, 1'b1);
    u_host.stop();
    u_host.start();
    sb(8'h94, 1'b0);
    u_host.stop();
    $display("test high address done");
    conclude();
  end
endmodule // tb_touch_ctrl_i2c_slave_write
